/* port_device_filter.v */
`timescale 1ns/1ps
`default_nettype none

module port_device_filter (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       attach_i,
  input  wire       detach_i,
  input  wire [7:0] dev_class_i,
  input  wire [7:0] dev_proto_i,
  input  wire       behind_hub_i,
  input  wire [7:0] want_proto_i,
  output reg        authorized_o,
  output reg        rejected_o
);

  `include "tamper_selftest_consts.vh"

  wire is_hub;
  wire type_ok;

  assign is_hub  = (dev_class_i == `TS_CLASS_HUB) | behind_hub_i;
  assign type_ok = (dev_class_i == `TS_CLASS_HID) & (dev_proto_i == want_proto_i);

  // every hub is refused outright, so nothing hidden behind one is ever trusted
  always @(posedge clk_i) begin
    if (srst_i) begin
      authorized_o <= 1'b0;
      rejected_o   <= 1'b0;
    end else begin
      rejected_o <= 1'b0;
      if (detach_i) begin
        authorized_o <= 1'b0;
      end else if (attach_i) begin
        authorized_o <= type_ok & ~is_hub;
        rejected_o   <= ~type_ok | is_hub;
      end
    end
  end

endmodule // port_device_filter

`default_nettype wire

/* self_test_responder.sv */
`timescale 1ns/1ps
`default_nettype none

// answers each start pulse once, promptly or six cycles late
module self_test_responder (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [3:0] fail_mask_i,
  input  wire logic       slow_i,
  output var  logic       done_o = 1'b0,
  output var  logic       pass_o = 1'b0
);
  logic       busy = 1'b0;
  logic [1:0] comp = 2'h0;
  logic [2:0] wait_cnt = 3'h0;

  always @(posedge clk_i) begin
    done_o <= 1'b0;
    // the result means nothing without done, so it wanders
    pass_o <= ~pass_o;
    if (rst_i) begin
      busy <= 1'b0;
    end else if (start_i) begin
      busy     <= 1'b1;
      comp     <= sel_i;
      wait_cnt <= slow_i ? 3'h6 : 3'h0;
    end else if (busy && wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end else if (busy) begin
      busy   <= 1'b0;
      done_o <= 1'b1;
      pass_o <= ~fail_mask_i[comp];
    end
  end
endmodule // self_test_responder

`default_nettype wire

/* tamper_selftest_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module tamper_selftest_checker (
  input wire logic       CLK_I,
  input wire logic       SRST_I,
  input wire logic       TAMPER_DET_I,
  input wire logic       BACKUP_FAIL_I,
  input wire logic       TAMPER_LATCH_SET_O,
  input wire logic [1:0] SEL_HOST_I,
  input wire logic       KBD_VALID_I,
  input wire logic [7:0] KBD_DATA_I,
  input wire logic [7:0] PTR_DATA_I,
  input wire logic [3:0] HOST_KBD_VALID_O,
  input wire logic [7:0] HOST_KBD_DATA_O,
  input wire logic [3:0] HOST_PTR_VALID_O,
  input wire logic [7:0] HOST_PTR_DATA_O,
  input wire logic       PERIPH_TX_VALID_O,
  input wire logic       DBG_ACK_O,
  input wire logic       KBD_ATTACH_I,
  input wire logic       KBD_DETACH_I,
  input wire logic       KBD_HUB_I,
  input wire logic       KBD_REJECT_O,
  input wire logic       LED_OK_O,
  input wire logic       LED_FAIL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  tamper_set_a: assert property (TAMPER_DET_I |-> ##[1:2] TAMPER_LATCH_SET_O)
    else $error("tamper report did not set the latch");
  backup_trip_a: assert property (BACKUP_FAIL_I |-> ##[1:2] TAMPER_LATCH_SET_O)
    else $error("backup supply failure did not set the latch");
  tamper_hold_a: assert property (TAMPER_LATCH_SET_O |=> TAMPER_LATCH_SET_O)
    else $error("tampered state cleared");
  tamper_block_a: assert property ((TAMPER_DET_I || BACKUP_FAIL_I || TAMPER_LATCH_SET_O)
    |=> HOST_KBD_VALID_O == 4'h0 && HOST_PTR_VALID_O == 4'h0)
    else $error("byte forwarded while tampered");
  no_reverse_a: assert property (!PERIPH_TX_VALID_O && !DBG_ACK_O)
    else $error("reverse or external access path active");
  kbd_route_a: assert property (HOST_KBD_VALID_O != 4'h0 |-> $past(KBD_VALID_I) &&
    HOST_KBD_VALID_O == 4'h1 << $past(SEL_HOST_I) && HOST_KBD_DATA_O == $past(KBD_DATA_I))
    else $error("keyboard byte misrouted");
  ptr_route_a: assert property (HOST_PTR_VALID_O != 4'h0 |->
    HOST_PTR_VALID_O == 4'h1 << $past(SEL_HOST_I) && HOST_PTR_DATA_O == $past(PTR_DATA_I))
    else $error("pointer byte misrouted");
  hub_reject_a: assert property (KBD_ATTACH_I && !KBD_DETACH_I && KBD_HUB_I |=> KBD_REJECT_O)
    else $error("hub not rejected");
  ok_fail_a: assert property (!(LED_OK_O && LED_FAIL_O))
    else $error("fail and ok indications together");
endmodule // tamper_selftest_checker

bind tamper_selftest_supervisor tamper_selftest_checker chk_inst (.*);

`default_nettype wire

/* tamper_selftest_consts.vh */
`ifndef TAMPER_SELFTEST_CONSTS_VH
`define TAMPER_SELFTEST_CONSTS_VH

// system clock period
`define TS_CLK_PERIOD_NS      20
// longest wait for one self-test step to answer: 10 us at the system clock
`define TS_ST_TIMEOUT_CYC     9'h1F4
// half period of the blinking tamper indicator: 250 ms at the system clock
`define TS_BLINK_HALF_CYC     28'h0BE_BC20

// self-test components, in test order
`define TS_COMP_KBD           2'h0
`define TS_COMP_PTR           2'h1
`define TS_COMP_HOST          2'h2
`define TS_COMP_CORE          2'h3
`define TS_COMP_LAST          2'h3
// a failure in a component of this mask, which holds only TS_COMP_CORE, disables the whole product
`define TS_CRIT_MASK          4'h8
`define TS_FAIL_MASK_RST      4'h0

// device identity values seen at enumeration
`define TS_CLASS_HID          8'h03
`define TS_CLASS_HUB          8'h09
`define TS_PROTO_KBD          8'h01
`define TS_PROTO_PTR          8'h02

// reset values
`define TS_DATA_RST           8'h00
`define TS_HOSTS_RST          4'h0

`endif

/* tamper_selftest_supervisor.v */
// Summary of operation
// - a report from the always-on tamper detector puts the block in a tampered state that no later input clears.
// - a failed or depleted anti-tamper backup supply also forces the tampered state.
// - in the tampered state no peripheral data reaches any host port.
// - a distinct blinking tamper indicator is driven whenever the tampered state is entered.
// - the self-test sequence runs after every power-up and powered reset that finds no tamper latched or reported, before forwarding starts.
// - a critical self-test failure disables the whole product, a non-critical one only the failed port, or both ports for a host-side failure.
// - a self-test failure lights its own indicator, distinct from the normal one.
// - keyboard and pointer data flow only from the peripheral to the selected host, never back.
// - the keyboard and pointer ports are kept isolated, with no data path between them.
// - each peripheral port accepts only its authorized device type and rejects every other.
// - hubs, and devices seen behind a hub, are rejected.
// - no external port offers a way to read or alter internal memory or firmware.
`timescale 1ns/1ps
`default_nettype none

`include "tamper_selftest_consts.vh"

module tamper_selftest_supervisor #(
  parameter [27:0] BLINK_HALF_CYC = `TS_BLINK_HALF_CYC
) (
  input  wire       CLK_I,
  input  wire       SRST_I,
  input  wire       TAMPER_DET_I,
  input  wire       BACKUP_FAIL_I,
  input  wire       TAMPER_LATCH_I,
  output reg        TAMPER_LATCH_SET_O,
  output reg        ST_START_O,
  output reg  [1:0] ST_SEL_O,
  input  wire       ST_DONE_I,
  input  wire       ST_PASS_I,
  input  wire [1:0] SEL_HOST_I,
  input  wire       KBD_VALID_I,
  input  wire [7:0] KBD_DATA_I,
  input  wire       PTR_VALID_I,
  input  wire [7:0] PTR_DATA_I,
  output reg  [3:0] HOST_KBD_VALID_O,
  output reg  [7:0] HOST_KBD_DATA_O,
  output reg  [3:0] HOST_PTR_VALID_O,
  output reg  [7:0] HOST_PTR_DATA_O,
  output wire       PERIPH_TX_VALID_O,
  input  wire       KBD_ATTACH_I,
  input  wire       KBD_DETACH_I,
  input  wire [7:0] KBD_CLASS_I,
  input  wire [7:0] KBD_PROTO_I,
  input  wire       KBD_HUB_I,
  output wire       KBD_REJECT_O,
  input  wire       PTR_ATTACH_I,
  input  wire       PTR_DETACH_I,
  input  wire [7:0] PTR_CLASS_I,
  input  wire [7:0] PTR_PROTO_I,
  input  wire       PTR_HUB_I,
  output wire       PTR_REJECT_O,
  input  wire       DBG_REQ_I,
  output wire       DBG_ACK_O,
  output reg        LED_TAMPER_O,
  output reg        LED_FAIL_O,
  output reg        LED_OK_O,
  output wire       OPERATING_O
);

  localparam [4:0] S_BOOT   = 5'b00001;
  localparam [4:0] S_TEST   = 5'b00010;
  localparam [4:0] S_RUN    = 5'b00100;
  localparam [4:0] S_FAIL   = 5'b01000;
  localparam [4:0] S_TAMPER = 5'b10000;

  localparam [8:0] TO_CYC = `TS_ST_TIMEOUT_CYC;

  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg         tampered;
  reg  [1:0]  comp;
  reg         st_wait;
  reg  [8:0]  to_cnt;
  reg  [3:0]  fail_mask;
  reg  [27:0] blink_cnt;
  reg         blink;

  wire        tamper_event;
  wire        step_done;
  wire        step_fail;
  wire [3:0]  next_fail_mask;
  wire        kbd_auth;
  wire        ptr_auth;
  wire        kbd_path_ok;
  wire        ptr_path_ok;

  // decode the selected host into a one-hot strobe vector
  function [3:0] host_onehot;
    input [1:0] sel;
    begin
      host_onehot = 4'h1 << sel;
    end
  endfunction

  // bit of the failure mask that belongs to one component
  function [3:0] comp_bit;
    input [1:0] c;
    begin
      comp_bit = 4'h1 << c;
    end
  endfunction

  assign tamper_event = TAMPER_DET_I | BACKUP_FAIL_I;

  assign step_done      = st_wait & (ST_DONE_I | (to_cnt == TO_CYC - 9'h001));
  // a step that times out counts as failed
  assign step_fail      = step_done & ~(ST_DONE_I & ST_PASS_I);
  assign next_fail_mask = fail_mask | (step_fail ? comp_bit(comp) : 4'h0);

  // state machine
  always @* begin
    next_state = state;
    case (state)
      S_BOOT: begin
        // the backup-powered latch is read before any test is launched
        if (TAMPER_LATCH_I | tamper_event) begin
          next_state = S_TAMPER;
        end else begin
          next_state = S_TEST;
        end
      end
      S_TEST: begin
        if (step_done && comp == `TS_COMP_LAST) begin
          if ((next_fail_mask & `TS_CRIT_MASK) != 4'h0) begin
            next_state = S_FAIL;
          end else begin
            next_state = S_RUN;
          end
        end
      end
      S_RUN: begin
        next_state = S_RUN;
      end
      S_FAIL: begin
        next_state = S_FAIL;
      end
      S_TAMPER: begin
        next_state = S_TAMPER;
      end
      default: begin
        next_state = S_TAMPER;
      end
    endcase
    // tamper pre-empts every other state
    if (tamper_event | tampered) begin
      next_state = S_TAMPER;
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      state <= S_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // tamper flag: set only, never cleared except by the reset that reloads it from
  // the backup latch; the latch itself lives outside and survives power loss
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      tampered           <= 1'b0;
      TAMPER_LATCH_SET_O <= 1'b0;
    end else begin
      if (tamper_event | (state == S_BOOT && TAMPER_LATCH_I)) begin
        tampered <= 1'b1;
      end
      if (tamper_event | tampered) begin
        TAMPER_LATCH_SET_O <= 1'b1;
      end
    end
  end

  // self-test sequencer
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      comp       <= `TS_COMP_KBD;
      st_wait    <= 1'b0;
      to_cnt     <= 9'h000;
      fail_mask  <= `TS_FAIL_MASK_RST;
      ST_START_O <= 1'b0;
      ST_SEL_O   <= `TS_COMP_KBD;
    end else begin
      ST_START_O <= 1'b0;
      if (state == S_TEST) begin
        if (!st_wait) begin
          ST_START_O <= 1'b1;
          ST_SEL_O   <= comp;
          st_wait    <= 1'b1;
          to_cnt     <= 9'h000;
        end else if (step_done) begin
          st_wait   <= 1'b0;
          fail_mask <= next_fail_mask;
          if (comp != `TS_COMP_LAST) begin
            comp <= comp + 2'h1;
          end
        end else begin
          to_cnt <= to_cnt + 9'h001;
        end
      end
    end
  end

  // enumeration checks, one filter per port
  port_device_filter u_kbd_filter (
    .clk_i        (CLK_I),
    .srst_i       (SRST_I),
    .attach_i     (KBD_ATTACH_I),
    .detach_i     (KBD_DETACH_I),
    .dev_class_i  (KBD_CLASS_I),
    .dev_proto_i  (KBD_PROTO_I),
    .behind_hub_i (KBD_HUB_I),
    .want_proto_i (`TS_PROTO_KBD),
    .authorized_o (kbd_auth),
    .rejected_o   (KBD_REJECT_O)
  );

  port_device_filter u_ptr_filter (
    .clk_i        (CLK_I),
    .srst_i       (SRST_I),
    .attach_i     (PTR_ATTACH_I),
    .detach_i     (PTR_DETACH_I),
    .dev_class_i  (PTR_CLASS_I),
    .dev_proto_i  (PTR_PROTO_I),
    .behind_hub_i (PTR_HUB_I),
    .want_proto_i (`TS_PROTO_PTR),
    .authorized_o (ptr_auth),
    .rejected_o   (PTR_REJECT_O)
  );

  // a port forwards only in normal operation, with a trusted device and a
  // passing self-test of that port and of the host side
  assign kbd_path_ok = (state == S_RUN) & ~tamper_event & kbd_auth
                     & ~fail_mask[`TS_COMP_KBD] & ~fail_mask[`TS_COMP_HOST];
  assign ptr_path_ok = (state == S_RUN) & ~tamper_event & ptr_auth
                     & ~fail_mask[`TS_COMP_PTR] & ~fail_mask[`TS_COMP_HOST];

  // each port has its own register set: keyboard bytes never feed the pointer
  // path or the other way round
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      HOST_KBD_VALID_O <= `TS_HOSTS_RST;
      HOST_KBD_DATA_O  <= `TS_DATA_RST;
    end else begin
      HOST_KBD_VALID_O <= `TS_HOSTS_RST;
      if (kbd_path_ok && KBD_VALID_I) begin
        HOST_KBD_VALID_O <= host_onehot(SEL_HOST_I);
        HOST_KBD_DATA_O  <= KBD_DATA_I;
      end
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      HOST_PTR_VALID_O <= `TS_HOSTS_RST;
      HOST_PTR_DATA_O  <= `TS_DATA_RST;
    end else begin
      HOST_PTR_VALID_O <= `TS_HOSTS_RST;
      if (ptr_path_ok && PTR_VALID_I) begin
        HOST_PTR_VALID_O <= host_onehot(SEL_HOST_I);
        HOST_PTR_DATA_O  <= PTR_DATA_I;
      end
    end
  end

  // there is no reverse path at all; a host can never talk to a peripheral
  assign PERIPH_TX_VALID_O = 1'b0;

  // the service request pin is never answered, so memory stays unreachable
  assign DBG_ACK_O = 1'b0 & DBG_REQ_I;

  assign OPERATING_O = (state == S_RUN);

  // blink divider for the tamper indicator
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      blink_cnt <= 28'h000_0000;
      blink     <= 1'b0;
    end else if (blink_cnt == BLINK_HALF_CYC - 28'h000_0001) begin
      blink_cnt <= 28'h000_0000;
      blink     <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 28'h000_0001;
    end
  end

  // tamper blinks red, a test failure is steady, normal operation has its own lamp
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      LED_TAMPER_O <= 1'b0;
      LED_FAIL_O   <= 1'b0;
      LED_OK_O     <= 1'b0;
    end else begin
      LED_TAMPER_O <= (state == S_TAMPER) & ~blink;
      LED_FAIL_O   <= (state == S_FAIL) | ((state == S_RUN) & (fail_mask != 4'h0));
      LED_OK_O     <= (state == S_RUN) & (fail_mask == 4'h0);
    end
  end

endmodule // tamper_selftest_supervisor

`default_nettype wire

/* tamper_selftest_supervisor_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tamper_selftest_supervisor_tb;
  // bench nets carry the pin names so the instance connects by name
  logic       CLK_I = 1'b0, SRST_I = 1'b1, TAMPER_DET_I = 1'b0, BACKUP_FAIL_I = 1'b0;
  logic       TAMPER_LATCH_I = 1'b0, TAMPER_LATCH_SET_O, ST_START_O, ST_DONE_I, ST_PASS_I;
  logic [1:0] ST_SEL_O, SEL_HOST_I = 2'h0;
  logic       KBD_VALID_I = 1'b0, PTR_VALID_I = 1'b0, DBG_REQ_I = 1'b0, DBG_ACK_O;
  logic [7:0] KBD_DATA_I = 8'h00, PTR_DATA_I = 8'h00, HOST_KBD_DATA_O, HOST_PTR_DATA_O;
  logic [3:0] HOST_KBD_VALID_O, HOST_PTR_VALID_O, fail_mask = 4'h0;
  logic       KBD_ATTACH_I = 1'b0, KBD_DETACH_I = 1'b0, KBD_HUB_I = 1'b0, KBD_REJECT_O;
  logic       PTR_ATTACH_I = 1'b0, PTR_DETACH_I = 1'b0, PTR_HUB_I = 1'b0, PTR_REJECT_O;
  logic [7:0] KBD_CLASS_I = 8'h00, KBD_PROTO_I = 8'h00, PTR_CLASS_I = 8'h00, PTR_PROTO_I = 8'h00;
  logic       PERIPH_TX_VALID_O, LED_TAMPER_O, LED_FAIL_O, LED_OK_O, OPERATING_O, lit = 1'b0;
  integer     seed = 34, err_total = 0, samples_checked = 0;

  tamper_selftest_supervisor #(.BLINK_HALF_CYC(28'h000_0004)) tamper_selftest_supervisor_inst (.*);
  self_test_responder self_test_responder_inst (.clk_i(CLK_I), .rst_i(SRST_I),
    .start_i(ST_START_O), .sel_i(ST_SEL_O), .fail_mask_i(fail_mask), .slow_i(seed[0]),
    .done_o(ST_DONE_I), .pass_o(ST_PASS_I));

  always #10 CLK_I = ~CLK_I;

  task automatic close_out;
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  task automatic chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t unexpected output", $time);
    end
  endtask

  function automatic logic bad(input logic [7:0] c, p, w, input logic h);
    return h || c != 8'h03 || p != w;
  endfunction

  task automatic boot(input logic [3:0] mask, input logic latch);
    int n;
    {fail_mask, TAMPER_LATCH_I, SRST_I} = {mask, latch, 1'b1};
    tick(2);
    SRST_I = 1'b0;
    n = 0;
    while (OPERATING_O !== 1'b1 && LED_FAIL_O !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (n == 100 && !latch) begin
      err_total++;
      $display("MISMATCH %0t self-test never finished", $time);
      close_out();
    end
    // the lamps are registered one cycle behind the state
    tick(1);
  endtask

  task automatic plug(input logic [7:0] kc, kp, pc, pp, input logic hub);
    {KBD_CLASS_I, KBD_PROTO_I, PTR_CLASS_I, PTR_PROTO_I} = {kc, kp, pc, pp};
    {KBD_ATTACH_I, PTR_ATTACH_I, KBD_HUB_I, PTR_HUB_I} = {2'b11, hub, hub};
    tick(1);
    {KBD_ATTACH_I, PTR_ATTACH_I, KBD_HUB_I, PTR_HUB_I} = 4'h0;
    chk(KBD_REJECT_O === bad(kc, kp, 8'h01, hub));
    chk(PTR_REJECT_O === bad(pc, pp, 8'h02, hub));
  endtask

  task automatic traffic(input int n, input logic kon, pon);
    int r;
    repeat (n) begin
      r = $random(seed);
      {KBD_DATA_I, PTR_DATA_I, KBD_VALID_I, PTR_VALID_I, SEL_HOST_I, DBG_REQ_I} = r[20:0];
      tick(1);
      lit = lit | LED_TAMPER_O;
      chk(HOST_KBD_VALID_O === (KBD_VALID_I && kon ? 4'h1 << SEL_HOST_I : 4'h0));
      chk(HOST_PTR_VALID_O === (PTR_VALID_I && pon ? 4'h1 << SEL_HOST_I : 4'h0));
      if (KBD_VALID_I && kon) chk(HOST_KBD_DATA_O === KBD_DATA_I);
      if (PTR_VALID_I && pon) chk(HOST_PTR_DATA_O === PTR_DATA_I);
      chk(PERIPH_TX_VALID_O === 1'b0 && DBG_ACK_O === 1'b0);
    end
  endtask

  initial begin
    boot(4'h0, 1'b0);
    chk(OPERATING_O === 1'b1 && LED_OK_O === 1'b1 && LED_FAIL_O === 1'b0);
    plug(8'h03, 8'h01, 8'h03, 8'h02, 1'b0);
    traffic(60, 1'b1, 1'b1);
    KBD_DETACH_I = 1'b1;
    tick(1);
    KBD_DETACH_I = 1'b0;
    traffic(10, 1'b0, 1'b1);
    plug(8'h03, 8'h01, 8'h03, 8'h02, 1'b1);
    traffic(10, 1'b0, 1'b0);
    plug(8'h09, 8'h01, 8'h03, 8'h01, 1'b0);
    traffic(10, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      boot(4'h1 << i, 1'b0);
      plug(8'h03, 8'h01, 8'h03, 8'h02, 1'b0);
      traffic(20, i == 1, i == 0);
      chk(LED_FAIL_O === 1'b1 && LED_OK_O === 1'b0 && OPERATING_O === (i != 3));
    end
    boot(4'h0, 1'b0);
    plug(8'h03, 8'h01, 8'h03, 8'h02, 1'b0);
    {TAMPER_DET_I, lit} = 2'b10;
    traffic(1, 1'b0, 1'b0);
    TAMPER_DET_I = 1'b0;
    traffic(12, 1'b0, 1'b0);
    chk(TAMPER_LATCH_SET_O === 1'b1 && OPERATING_O === 1'b0 && lit === 1'b1);
    boot(4'h0, 1'b1);
    traffic(10, 1'b0, 1'b0);
    chk(TAMPER_LATCH_SET_O === 1'b1 && OPERATING_O === 1'b0 && LED_OK_O === 1'b0);
    boot(4'h0, 1'b0);
    plug(8'h03, 8'h01, 8'h03, 8'h02, 1'b0);
    BACKUP_FAIL_I = 1'b1;
    traffic(3, 1'b0, 1'b0);
    BACKUP_FAIL_I = 1'b0;
    traffic(5, 1'b0, 1'b0);
    chk(TAMPER_LATCH_SET_O === 1'b1 && OPERATING_O === 1'b0);
    close_out();
  end
endmodule // tamper_selftest_supervisor_tb

`default_nettype wire
